// File: design/hcp_consts.svh
`ifndef HCP_CONSTS_SVH
`define HCP_CONSTS_SVH

// ==========================================================
// register byte offsets
`define HCP_OFS_IRQCFG   8'h00
`define HCP_OFS_RXLEN    8'h04
`define HCP_OFS_CMD      8'h08
`define HCP_OFS_QSTAT    8'h0C
`define HCP_OFS_RXDATA   8'h10
`define HCP_OFS_TXDATA   8'h14
`define HCP_OFS_GLOBAL   8'h18
`define HCP_OFS_STAT0    8'h20
`define HCP_OFS_MASK0    8'h30

// ==========================================================
// field positions
`define HCP_CFG_OPENDRAIN 0
`define HCP_CFG_VISIBLE   1
`define HCP_CMD_RXRELEASE 0
`define HCP_CMD_TXCOMMIT  1
`define HCP_EV_RXREADY    0
`define HCP_EV_TXFREE     1
`define HCP_EV_RXOVERRUN  2

// ==========================================================
// reset values and queue sizes
`define HCP_HALF_DEPTH  32
`define HCP_RXLEN_MIN   7'h02
`define HCP_RXLEN_RESET 7'h20

`endif

// File: design/hcp_pkg.sv
package hcp_pkg;

	typedef logic [6:0] hcp_cnt_t;

	typedef enum logic [1:0]
	{
		HCP_FIRST_DEMUX,
		HCP_FIRST_MUX,
		HCP_SECOND_DEMUX
	} hcp_style_t;

	typedef struct packed
	{
		logic       wrHalf;
		hcp_cnt_t   wrCnt;
		logic       rdHalf;
		hcp_cnt_t   rdCnt;
		logic [1:0] full;
		hcp_cnt_t   len0;
		hcp_cnt_t   len1;
	} hcp_queue_state_t;

	typedef struct packed
	{
		logic             ack;
		logic [31:0]      datOut;
		logic             openDrain;
		logic             visible;
		hcp_cnt_t         rxLen;
		logic [3:0][7:0]  status;
		logic [3:0][7:0]  pending;
		logic [3:0][7:0]  mask;
		logic [3:0]       global;
		logic             irqLevel;
		logic             irqPinOut;
		logic             irqPinOe;
		logic             latchPrev;
		logic             latchToggled;
		logic             strapDone;
		logic             wide;
		hcp_style_t       style;
		logic             txValid;
		logic [7:0]       txData;
		logic             rxAvailPrev;
		logic             txFreePrev;
	} hcp_top_state_t;

endpackage

// File: design/hcp_queue_if.sv
interface hcp_queue_if;
	import hcp_pkg::*;

	logic        push;
	logic        pushTwo;
	logic [15:0] pushData;
	logic        commit;
	hcp_cnt_t    limit;
	logic        canOne;
	logic        canTwo;
	logic        pop;
	logic        popTwo;
	logic [15:0] peek;
	logic        availOne;
	logic        availTwo;
	logic        release_;
	logic        autoRelease;
	logic        writerFull;

	modport queue
	(
		input  push, pushTwo, pushData, commit, limit,
		input  pop, popTwo, release_, autoRelease,
		output canOne, canTwo, peek, availOne, availTwo, writerFull
	);

	modport user
	(
		output push, pushTwo, pushData, commit, limit,
		output pop, popTwo, release_, autoRelease,
		input  canOne, canTwo, peek, availOne, availTwo, writerFull
	);
endinterface

// File: design/hcp_queue.sv
`include "hcp_consts.svh"
module hcp_queue
	import hcp_pkg::*;
#(
	parameter int HALF_DEPTH = `HCP_HALF_DEPTH
)
(
	input  wire logic   clk_sys,
	input  wire logic   rst,
	input  wire logic   ce,
	hcp_queue_if.queue  q
);
	localparam int AW = $clog2(2 * HALF_DEPTH);

	// ==========================================================
	// parameter check
	initial
	begin
		if (HALF_DEPTH < 2 || HALF_DEPTH > 64 ||
			(HALF_DEPTH & (HALF_DEPTH - 1)) != 0)
			$error("hcp_queue: HALF_DEPTH must be a power of 2, 2..64");
	end

	hcp_queue_state_t s;
	hcp_queue_state_t next_s;
	logic [7:0]       mem [0:2*HALF_DEPTH-1];
	logic             wrOk;
	logic [AW-1:0]    wrAddr;
	logic [AW-1:0]    rdAddr;
	hcp_cnt_t         wrNew;
	hcp_cnt_t         rdNew;
	hcp_cnt_t         rdLen;

	// byte address inside the 2*HALF_DEPTH-entry store; wraps within its width
	function automatic logic [AW-1:0] addrOf(input logic half,
		input hcp_cnt_t cnt);
		logic [7:0] full8;
		full8 = {7'h00, half} * 8'(HALF_DEPTH) + {1'b0, cnt};
		return full8[AW-1:0];
	endfunction

	assign wrAddr = addrOf(s.wrHalf, s.wrCnt);
	assign rdAddr = addrOf(s.rdHalf, s.rdCnt);
	assign rdLen  = s.rdHalf ? s.len1 : s.len0;

	// ==========================================================
	// writer fills one half while the reader owns the other
	always_comb
	begin
		next_s       = s;
		q.writerFull = s.full[s.wrHalf];
		q.canOne     = !s.full[s.wrHalf] && (s.wrCnt < q.limit);
		q.canTwo     = !s.full[s.wrHalf] &&
			(s.wrCnt + 7'h02 <= q.limit);
		q.availOne   = s.full[s.rdHalf] && (s.rdCnt < rdLen);
		q.availTwo   = s.full[s.rdHalf] && (s.rdCnt + 7'h02 <= rdLen);
		q.peek       = {mem[AW'(rdAddr + 1'b1)], mem[rdAddr]};
		wrOk  = q.push && (q.pushTwo ? q.canTwo : q.canOne);
		wrNew = s.wrCnt + (wrOk ? (q.pushTwo ? 7'h02 : 7'h01) : 7'h00);
		next_s.wrCnt = wrNew;
		// hand a half to the reader when full or on request
		if ((wrNew >= q.limit || q.commit) && wrNew != 7'h00 &&
			!s.full[s.wrHalf])
		begin
			next_s.full[s.wrHalf] = 1'b1;
			if (s.wrHalf)
				next_s.len1 = wrNew;
			else
				next_s.len0 = wrNew;
			next_s.wrHalf = !s.wrHalf;
			next_s.wrCnt  = 7'h00;
		end
		rdNew = s.rdCnt;
		if (q.pop && (q.popTwo ? q.availTwo : q.availOne))
			rdNew = s.rdCnt + (q.popTwo ? 7'h02 : 7'h01);
		next_s.rdCnt = rdNew;
		// a half goes back to the writer on release, or once drained with auto release
		if (s.full[s.rdHalf] &&
			(q.release_ || (q.autoRelease && rdNew >= rdLen)))
		begin
			next_s.full[s.rdHalf] = 1'b0;
			next_s.rdHalf = !s.rdHalf;
			next_s.rdCnt  = 7'h00;
		end
	end

	// ==========================================================
	// state register
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
			s <= '0;
		else if (ce)
			s <= next_s;
	end

	// ==========================================================
	// storage; no reset needed, reads are gated by the counters
	always_ff @(posedge clk_sys)
	begin
		if (ce && wrOk)
		begin
			mem[wrAddr] <= q.pushData[7:0];
			if (q.pushTwo)
				mem[AW'(wrAddr + 1'b1)] <= q.pushData[15:8];
		end
	end
endmodule

// File: design/hcp_host_port.sv
// Operation
// - bus style from mode pin and latch activity
// - even address lane depends on bus style
// - two 32-byte halves per direction, one visible
// - word queue access only on wide bus
// - receive half length 32 down to 2
// - single interrupt pin, open drain or push-pull
// - reading status clears returned bits
// - masked events hidden and silent normally
// - global pointer flags registers with unmasked events
// - interrupt drops once pointer fully clear
// - no status update during status read
// - visible mode latches masked events silently
// - visible mode read clears all active bits
// - lane enables and A0 select transfer width
// - byte and word queue accesses mix freely
`include "hcp_consts.svh"
module hcp_host_port
	import hcp_pkg::*;
#(
	parameter int HALF_DEPTH = `HCP_HALF_DEPTH
)
(
	input  wire logic        clk_sys,
	input  wire logic        rst,
	input  wire logic        ce,
	input  wire logic        cyc_i,
	input  wire logic        stb_i,
	input  wire logic        we_i,
	input  wire logic [7:0]  adr_i,
	input  wire logic [3:0]  sel_i,
	input  wire logic [31:0] dat_i,
	output logic      [31:0] dat_o,
	output logic             ack_o,
	input  wire logic        busStyleSelect,
	input  wire logic        latchEnable,
	input  wire logic        busWidthSelect,
	input  wire logic [31:0] eventIn,
	input  wire logic        rxLineValid,
	input  wire logic [7:0]  rxLineData,
	input  wire logic        txLineReady,
	output logic             txLineValid,
	output logic      [7:0]  txLineData,
	output logic             irqLevel,
	output logic             irqPinOut,
	output logic             irqPinOe
);
	// ==========================================================
	// parameter check
	initial
	begin
		if (HALF_DEPTH != `HCP_HALF_DEPTH)
			$error("hcp_host_port: HALF_DEPTH must be 32");
	end

	hcp_top_state_t s;
	hcp_top_state_t next_s;
	hcp_queue_if    rxQ ();
	hcp_queue_if    txQ ();
	logic           req;
	logic           take;
	logic           rdFreeze;
	logic [7:0]     ofs;
	logic [31:0]    rdVal;
	logic           laneLo;
	logic           laneHi;
	logic           isWord;
	logic           isByte;
	logic [31:0]    ev;
	logic [3:0]     hit;

	// even-address byte rides on the high lane in the second style
	function automatic logic evenOnHigh(input hcp_style_t st);
		return st == HCP_SECOND_DEMUX;
	endfunction

	// keep a programmed receive length inside 2..32
	function automatic hcp_cnt_t clampLen(input logic [6:0] v);
		if (v < `HCP_RXLEN_MIN)
			return `HCP_RXLEN_MIN;
		if (v > 7'(HALF_DEPTH))
			return 7'(HALF_DEPTH);
		return v;
	endfunction

	// ==========================================================
	// queues
	hcp_queue #(.HALF_DEPTH(HALF_DEPTH)) rxQueue
	(
		.clk_sys (clk_sys),
		.rst     (rst),
		.ce      (ce),
		.q       (rxQ.queue)
	);

	hcp_queue #(.HALF_DEPTH(HALF_DEPTH)) txQueue
	(
		.clk_sys (clk_sys),
		.rst     (rst),
		.ce      (ce),
		.q       (txQ.queue)
	);

	// ==========================================================
	// bus decode; answer comes one cycle after the request
	assign req    = cyc_i && stb_i;
	assign take   = req && !s.ack;
	assign ofs    = {adr_i[7:2], 2'b00};
	assign hit[0] = ofs == `HCP_OFS_STAT0;
	assign hit[1] = ofs == `HCP_OFS_STAT0 + 8'h04;
	assign hit[2] = ofs == `HCP_OFS_STAT0 + 8'h08;
	assign hit[3] = ofs == `HCP_OFS_STAT0 + 8'h0C;
	// the whole read holds the status and pointer still
	assign rdFreeze = req && !we_i && ((|hit) || ofs == `HCP_OFS_GLOBAL);

	// lane enables stand in for the byte enable and A0 pins
	assign laneLo = sel_i[0];
	assign laneHi = sel_i[1];
	// word access to the queues only on the wide bus
	assign isWord = laneLo && laneHi && s.wide;
	assign isByte = (laneLo ^ laneHi) || (laneLo && laneHi && !s.wide);

	// internal events land in the first status register
	always_comb
	begin
		ev = eventIn;
		ev[`HCP_EV_RXREADY]   = eventIn[`HCP_EV_RXREADY] ||
			(rxQ.availOne && !s.rxAvailPrev);
		ev[`HCP_EV_TXFREE]    = eventIn[`HCP_EV_TXFREE] ||
			(!txQ.writerFull && !s.txFreePrev);  // rising edge only
		ev[`HCP_EV_RXOVERRUN] = eventIn[`HCP_EV_RXOVERRUN] ||
			(rxLineValid && !rxQ.canOne);
	end

	// ==========================================================
	// queue steering
	always_comb
	begin
		// receive writer is the line, auto handed at the length
		rxQ.push        = rxLineValid;
		rxQ.pushTwo     = 1'b0;
		rxQ.pushData    = {8'h00, rxLineData};
		rxQ.commit      = 1'b0;
		rxQ.limit       = s.rxLen;
		rxQ.autoRelease = 1'b0;
		rxQ.release_    = take && we_i && ofs == `HCP_OFS_CMD &&
			dat_i[`HCP_CMD_RXRELEASE];
		// byte and word pops may follow in any order
		rxQ.pop         = take && !we_i && ofs == `HCP_OFS_RXDATA &&
			(isWord || isByte);
		rxQ.popTwo      = isWord;
		// transmit writer is software, half handed when full
		txQ.limit       = 7'(HALF_DEPTH);
		txQ.commit      = take && we_i && ofs == `HCP_OFS_CMD &&
			dat_i[`HCP_CMD_TXCOMMIT];
		txQ.push        = take && we_i && ofs == `HCP_OFS_TXDATA &&
			(isWord || isByte);
		txQ.pushTwo     = isWord;
		// first byte of a word comes from the even-address lane
		if (isWord)
			txQ.pushData = evenOnHigh(s.style) ?
				{dat_i[7:0], dat_i[15:8]} : dat_i[15:0];
		else
			txQ.pushData = {8'h00,
				(laneHi && !laneLo) ? dat_i[15:8] : dat_i[7:0]};
		txQ.pop         = txQ.availOne && (!s.txValid || txLineReady);
		txQ.popTwo      = 1'b0;
		txQ.autoRelease = 1'b1;
		txQ.release_    = 1'b0;
	end

	// ==========================================================
	// read mux
	always_comb
	begin
		rdVal = 32'h0000_0000;
		case (ofs)
			`HCP_OFS_IRQCFG: rdVal = {30'h0, s.visible, s.openDrain};
			`HCP_OFS_RXLEN:  rdVal = {25'h0, s.rxLen};
			`HCP_OFS_QSTAT:  rdVal = {22'h0, s.style, 4'h0, s.wide,
				!txQ.writerFull, rxQ.availTwo, rxQ.availOne};
			`HCP_OFS_RXDATA:
			begin
				if (isWord)
					rdVal = evenOnHigh(s.style) ?
						{16'h0, rxQ.peek[7:0], rxQ.peek[15:8]} :
						{16'h0, rxQ.peek};
				else if (isByte && laneHi && !laneLo)
					rdVal = {16'h0, rxQ.peek[7:0], 8'h00};
				else if (isByte)
					rdVal = {24'h0, rxQ.peek[7:0]};
				else
					rdVal = 32'h0000_0000;  // no transfer
			end
			`HCP_OFS_GLOBAL: rdVal = {28'h0, s.global};
			default:
			begin
				for (int i = 0; i < 4; i++)
				begin
					if (hit[i])
						rdVal = {24'h0, s.status[i]};
					if (ofs == `HCP_OFS_MASK0 + 8'(4 * i))
						rdVal = {24'h0, s.mask[i]};
				end
			end
		endcase
	end

	// ==========================================================
	// next state
	always_comb
	begin
		next_s = s;
		next_s.ack = take;
		if (take)
			next_s.datOut = we_i ? 32'h0000_0000 : rdVal;
		// style: a toggling latch enable means a multiplexed bus
		next_s.latchPrev = latchEnable;
		if (s.strapDone && latchEnable != s.latchPrev)
			next_s.latchToggled = 1'b1;
		if (busStyleSelect)
			next_s.style = HCP_SECOND_DEMUX;
		else if (next_s.latchToggled)
			next_s.style = HCP_FIRST_MUX;
		else
			next_s.style = HCP_FIRST_DEMUX;
		// width strap caught once after reset release
		if (!s.strapDone)
		begin
			next_s.strapDone = 1'b1;
			next_s.wide      = busWidthSelect;
		end
		// configuration writes
		if (take && we_i)
		begin
			if (ofs == `HCP_OFS_IRQCFG && sel_i[0])
			begin
				next_s.openDrain = dat_i[`HCP_CFG_OPENDRAIN];
				next_s.visible   = dat_i[`HCP_CFG_VISIBLE];
			end
			if (ofs == `HCP_OFS_RXLEN && sel_i[0])
				next_s.rxLen = clampLen(dat_i[6:0]);
			for (int i = 0; i < 4; i++)
				if (ofs == `HCP_OFS_MASK0 + 8'(4 * i) && sel_i[0])
					next_s.mask[i] = dat_i[7:0];
		end
		// events: held while a status read runs, posted after it
		for (int i = 0; i < 4; i++)
		begin
			if (rdFreeze)
				next_s.pending[i] = s.pending[i] | ev[8*i +: 8];
			else
			begin
				// masked bits latch only in visible mode
				next_s.status[i] = s.status[i] |
					((ev[8*i +: 8] | s.pending[i]) &
					(s.visible ? 8'hFF : ~s.mask[i]));
				next_s.pending[i] = 8'h00;
			end
			// read returns and clears every latched bit
			if (take && !we_i && hit[i])
				next_s.status[i] = 8'h00;
		end
		// pointer counts only unmasked bits; frozen during status and pointer reads
		if (!rdFreeze)
			for (int i = 0; i < 4; i++)
				next_s.global[i] = |(next_s.status[i] & ~s.mask[i]);
		// interrupt stays until the pointer is all clear
		next_s.irqLevel = |next_s.global;
		// active-low pin: released or driven high when idle
		next_s.irqPinOut = s.openDrain ? 1'b0 : !next_s.irqLevel;
		next_s.irqPinOe  = s.openDrain ? next_s.irqLevel : 1'b1;
		// line transmit holding register
		if (txQ.pop)
		begin
			next_s.txValid = 1'b1;
			next_s.txData  = txQ.peek[7:0];
		end
		else if (txLineReady)
			next_s.txValid = 1'b0;
		next_s.rxAvailPrev = rxQ.availOne;
		next_s.txFreePrev  = !txQ.writerFull;
	end

	// ==========================================================
	// state register; ce low freezes everything
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			s           <= '0;
			s.rxLen     <= `HCP_RXLEN_RESET;
			s.irqPinOe  <= 1'b1;
			s.irqPinOut <= 1'b1;
			s.txFreePrev <= 1'b1;
		end
		else if (ce)
			s <= next_s;
	end

	// ==========================================================
	// outputs, all straight from the state register
	assign dat_o       = s.datOut;
	assign ack_o       = s.ack;
	assign txLineValid = s.txValid;
	assign txLineData  = s.txData;
	assign irqLevel    = s.irqLevel;
	assign irqPinOut   = s.irqPinOut;
	assign irqPinOe    = s.irqPinOe;
endmodule

// File: dv/hcp_host_port_chk.sv
`include "hcp_consts.svh"
module hcp_host_port_chk
(
	input  wire logic        clk_sys,
	input  wire logic        rst,
	input  wire logic        ce,
	input  wire logic        cyc_i,
	input  wire logic        stb_i,
	input  wire logic [31:0] eventIn,
	input  wire logic        rxLineValid,
	input  wire logic        txLineReady,
	input  wire logic        txLineValid,
	input  wire logic  [7:0] txLineData,
	input  wire logic [31:0] dat_o,
	input  wire logic        ack_o,
	input  wire logic        irqLevel,
	input  wire logic        irqPinOut,
	input  wire logic        irqPinOe
);
	logic       taken;
	logic [2:0] causeAge;

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);

	// ==========================================================
	// helpers
	// a request counts only on an enabled edge while ack is low
	assign taken = cyc_i && stb_i && !ack_o && ce;

	// ages any cause of an interrupt; wide enough for a posted event
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
			causeAge <= 3'h0;
		else if (|eventIn || rxLineValid || ack_o || txLineValid)
			causeAge <= 3'h7;
		else if (causeAge != 3'h0)
			causeAge <= causeAge - 3'h1;
	end

	// ==========================================================
	// assertions
	a_ack_after_take: assert property (
		taken |=> ack_o) else $error("no ack after request");
	a_ack_one_cycle: assert property (
		ack_o && ce |=> !ack_o) else $error("ack longer than one cycle");
	a_ack_has_request: assert property (
		ack_o && $past(ce) |-> $past(taken)) else $error("ack unasked");
	a_rdata_steady: assert property (
		$changed(dat_o) |-> $past(taken)) else $error("read data moved");
	a_pin_follows_irq: assert property (
		(irqPinOe && !irqPinOut) == irqLevel) else $error("pin level wrong");
	a_irq_has_cause: assert property (
		$rose(irqLevel) |-> causeAge != 3'h0) else $error("irq without event");
	a_irq_drop_read: assert property (
		$fell(irqLevel) |-> $past(ack_o) || $past(ack_o, 2)
			|| $past(ack_o, 3) || $past(ack_o, 4))
		else $error("irq fell without access");
	a_tx_held: assert property (
		txLineValid && !txLineReady && ce |=> txLineValid
			&& $stable(txLineData)) else $error("tx byte not held");
endmodule

bind hcp_host_port hcp_host_port_chk hcp_host_port_chk_inst
(
	.clk_sys(clk_sys), .rst(rst), .ce(ce), .cyc_i(cyc_i), .stb_i(stb_i),
	.eventIn(eventIn), .rxLineValid(rxLineValid), .txLineReady(txLineReady),
	.txLineValid(txLineValid), .txLineData(txLineData), .dat_o(dat_o),
	.ack_o(ack_o), .irqLevel(irqLevel), .irqPinOut(irqPinOut),
	.irqPinOe(irqPinOe)
);

// File: dv/hcp_line_model.sv
module hcp_line_model
(
	input  wire logic clk_sys,
	output logic      rxLineValid,
	output logic [7:0] rxLineData,
	output logic      txLineReady
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] rxQ[$];

	initial
	begin
		rxLineValid = 1'b0;
		rxLineData = 8'h5A;
		txLineReady = 1'b0;
	end

	// one queued byte a cycle; idle data flips so stale bytes never match
	always @(posedge clk_sys)
	begin
		txLineReady <= 1'($urandom_range(1, 0));
		rxLineValid <= (rxQ.size() > 0);
		rxLineData <= (rxQ.size() > 0) ? rxQ.pop_front() : ~rxLineData;
	end
endmodule

// File: dv/hcp_host_port_bench.sv
`include "hcp_consts.svh"
module hcp_host_port_bench;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk_sys = 1'b0;
	logic        rst = 1'b1;
	logic        cyc_i = 1'b0;
	logic        stb_i = 1'b0;
	logic        we_i = 1'b0;
	logic  [7:0] adr_i = 8'h00;
	logic  [3:0] sel_i = 4'h0;
	logic [31:0] dat_i = 32'h0;
	logic [31:0] eventIn = 32'h0;
	logic        busStyleSelect = 1'b0;
	logic        latchEnable = 1'b0;
	logic        busWidthSelect = 1'b1;
	logic [31:0] dat_o;
	logic        ack_o, rxLineValid, txLineReady, txLineValid;
	logic  [7:0] rxLineData, txLineData, t0, t1, t2;
	logic        irqLevel, irqPinOut, irqPinOe;
	logic [63:0] expQ[$];
	logic [63:0] note;
	logic  [7:0] expTx[$];
	int          n_fail = 0;
	int          num_checks = 0;
	int          cycles = 0;
	int          j;

	always #5 clk_sys = ~clk_sys;

	hcp_host_port hcp_host_port_inst
	(
		.clk_sys(clk_sys), .rst(rst), .ce(1'b1), .cyc_i(cyc_i),
		.stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i),
		.dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
		.busStyleSelect(busStyleSelect), .latchEnable(latchEnable),
		.busWidthSelect(busWidthSelect), .eventIn(eventIn),
		.rxLineValid(rxLineValid), .rxLineData(rxLineData),
		.txLineReady(txLineReady), .txLineValid(txLineValid),
		.txLineData(txLineData), .irqLevel(irqLevel),
		.irqPinOut(irqPinOut), .irqPinOe(irqPinOe)
	);

	hcp_line_model hcp_line_model_inst
	(
		.clk_sys(clk_sys), .rxLineValid(rxLineValid),
		.rxLineData(rxLineData), .txLineReady(txLineReady)
	);

	// ==========================================================
	// checking
	task automatic cmpVal(input logic [31:0] got, exp, mask);
		num_checks++;
		if ((got & mask) !== (exp & mask))
		begin
			n_fail++;
			$display("BAD t=%0t got=%h exp=%h", $time, got & mask, exp & mask);
		end
	endtask

	task automatic cmpTx(input logic [7:0] got, exp);
		cmpVal({24'h0, got}, {24'h0, exp}, 32'hFF);
	endtask

	// oldest note meets each answer; also cuts a hang short
	always @(posedge clk_sys)
	begin
		cycles++;
		if (ack_o === 1'b1 && expQ.size() > 0)
		begin
			note = expQ.pop_front();
			cmpVal(dat_o, note[63:32], note[31:0]);
		end
		if (txLineValid === 1'b1 && txLineReady === 1'b1)
			cmpTx(txLineData, expTx.size() ? expTx.pop_front() : ~txLineData);
		if (cycles == 20000)
		begin
			n_fail++;
			report_and_stop;
		end
	end

	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	// ==========================================================
	// bus and event drivers
	// holds the request until ack is sampled, then idles one cycle
	task automatic busIo(input logic w, input logic [7:0] a,
		input logic [3:0] s, input logic [31:0] d, e, m);
		expQ.push_back({e, m});
		{cyc_i, stb_i, we_i, adr_i, sel_i, dat_i} <= {2'b11, w, a, s, d};
		// only the bench timeout ends this wait
		do
			@(posedge clk_sys);
		while (ack_o !== 1'b1);
		{cyc_i, stb_i} <= 2'b00;
		@(posedge clk_sys);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] e, m);
		busIo(1'b0, a, 4'hF, 32'h0, e, m);
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		busIo(1'b1, a, 4'hF, d, 32'h0, 32'h0);
	endtask

	task automatic idle(input int n);
		repeat (n) @(posedge clk_sys);
	endtask

	task automatic pulse(input logic [31:0] v);
		eventIn <= v;
		@(posedge clk_sys);
		eventIn <= 32'h0;
	endtask

	task automatic waitIrq(input logic l);
		for (int n = 0; n < 200 && irqLevel !== l; n++)
			@(posedge clk_sys);
		cmpVal({31'h0, irqLevel}, {31'h0, l}, 32'h1);
	endtask

	// a byte still expected after the wait counts as lost
	task automatic drainTx;
		for (int n = 0; n < 300 && expTx.size() > 0; n++)
			@(posedge clk_sys);
		cmpVal(32'(expTx.size()), 32'h0, 32'hFF);
	endtask

	task automatic clearAll;
		idle(8);
		for (int k = 0; k < 4; k++)
			rd(8'(`HCP_OFS_STAT0 + 4 * k), 32'h0, 32'h0);
		idle(4);
	endtask

	// second style puts the first queued byte on the high lane
	task automatic rxWord(input logic sw);
		t0 = 8'($urandom);
		t1 = 8'($urandom);
		hcp_line_model_inst.rxQ.push_back(t0);
		hcp_line_model_inst.rxQ.push_back(t1);
		waitIrq(1'b1);
		rd(`HCP_OFS_STAT0, 32'h1, 32'h1);
		rd(`HCP_OFS_RXDATA, sw ? {t0, t1} : {t1, t0}, 32'hFFFF);
		wr(`HCP_OFS_CMD, 32'h1);
		idle(4);
	endtask

	// ==========================================================
	// tests
	initial
	begin
		void'($urandom(32'h92121907));
		repeat (8) @(posedge clk_sys);
		rst <= 1'b0;
		idle(2);
		rd(`HCP_OFS_IRQCFG, 32'h0, 32'h3);
		rd(`HCP_OFS_RXLEN, 32'h20, 32'h7F);
		rd(`HCP_OFS_MASK0, 32'h0, 32'hFF);
		rd(`HCP_OFS_QSTAT, 32'h8, 32'h308);
		rd(8'h40, 32'h0, 32'hFFFFFFFF);
		wr(`HCP_OFS_RXLEN, 32'h1);
		rd(`HCP_OFS_RXLEN, 32'h2, 32'h7F);
		wr(`HCP_OFS_RXLEN, 32'h3F);
		rd(`HCP_OFS_RXLEN, 32'h20, 32'h7F);
		wr(`HCP_OFS_RXLEN, 32'h2);
		$display("test registers done");
		clearAll;
		rxWord(1'b0);
		busStyleSelect <= 1'b1;
		idle(1);
		rd(`HCP_OFS_QSTAT, 32'h208, 32'h308);
		rxWord(1'b1);
		busStyleSelect <= 1'b0;
		busIo(1'b0, `HCP_OFS_RXDATA, 4'h0, 32'h0, 0, 32'hFFFF);
		$display("test receive done");
		{t0, t1, t2} = 24'($urandom);
		expTx = '{t0, t1, t2};
		busIo(1'b1, `HCP_OFS_TXDATA, 4'h1, {24'h0, t0}, 0, 0);
		busIo(1'b1, `HCP_OFS_TXDATA, 4'h3, {16'h0, t2, t1}, 0, 0);
		wr(`HCP_OFS_CMD, 32'h2);
		drainTx;
		$display("test transmit done");
		clearAll;
		for (int k = 0; k < 4; k++)
		begin
			j = 3 + int'($urandom_range(4, 0));
			pulse(32'h1 << (8 * k + j));
			waitIrq(1'b1);
			rd(`HCP_OFS_GLOBAL, 32'h1 << k, 32'hF);
			rd(8'(`HCP_OFS_STAT0 + 4 * k), 32'h1 << j, 32'hFF);
			rd(8'(`HCP_OFS_STAT0 + 4 * k), 32'h0, 32'hFF);
			waitIrq(1'b0);
			rd(`HCP_OFS_GLOBAL, 32'h0, 32'hF);
		end
		$display("test events done");
		wr(8'h34, 32'h10);
		pulse(32'h1000);
		idle(4);
		rd(`HCP_OFS_GLOBAL, 32'h0, 32'hF);
		rd(8'h24, 32'h0, 32'hFF);
		wr(`HCP_OFS_IRQCFG, 32'h3);
		pulse(32'h3000);
		waitIrq(1'b1);
		idle(2);
		cmpVal({30'h0, irqPinOe, irqPinOut}, 32'h2, 32'h3);
		rd(`HCP_OFS_GLOBAL, 32'h2, 32'hF);
		rd(8'h24, 32'h30, 32'hFF);
		rd(8'h24, 32'h0, 32'hFF);
		waitIrq(1'b0);
		idle(2);
		cmpVal({30'h0, irqPinOe, irqPinOut}, 32'h0, 32'h3);
		wr(8'h34, 32'h0);
		wr(`HCP_OFS_IRQCFG, 32'h0);
		idle(2);
		cmpVal({30'h0, irqPinOe, irqPinOut}, 32'h3, 32'h3);
		$display("test masks done");
		fork
			rd(8'h28, 32'h0, 32'hFF);
			begin
				@(posedge clk_sys);
				pulse(32'h10000);
			end
		join
		idle(4);
		rd(8'h28, 32'h1, 32'hFF);
		latchEnable <= 1'b1;
		idle(2);
		rd(`HCP_OFS_QSTAT, 32'h108, 32'h308);
		$display("test read hold done");
		// second reset with the narrow strap; a word write is one byte
		busWidthSelect <= 1'b0;
		rst <= 1'b1;
		idle(2);
		rst <= 1'b0;
		idle(2);
		rd(`HCP_OFS_QSTAT, 32'h0, 32'h308);
		t0 = 8'($urandom);
		expTx = '{t0};
		busIo(1'b1, `HCP_OFS_TXDATA, 4'h3, {16'h0, ~t0, t0}, 0, 0);
		wr(`HCP_OFS_CMD, 32'h2);
		drainTx;
		$display("test narrow bus done");
		report_and_stop;
	end
endmodule
